// ==== hdl/pnsb_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module pnsb_bank
	import pnsb_pkg::*;
#(
	parameter bit BIDIR_PORT_OPTION  = 1'b0,
	parameter bit PORT_E_MODE_OPTION = 1'b1,
	parameter bit TEN_BIT_OPTION     = 1'b0,
	parameter bit TWELVE_BIT_OPTION  = 1'b0,
	parameter bit TRIM_OPTION        = 1'b0
)(
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire pnsb_req_t   req_i,
	input  wire logic        page_load_i,
	input  wire logic [1:0]  page_data_i,
	input  wire logic        alu_flags_we_i,
	input  wire logic        carry_in_i,
	input  wire logic        zero_in_i,
	input  wire logic        pwm_irq_set_i,
	input  wire logic        irq_entry_i,
	input  wire logic        irq_return_i,
	input  wire logic        spk_wake_i,
	input  wire logic [3:0]  port_a_pin_i,
	input  wire logic [3:0]  port_b_pin_i,
	input  wire logic [3:0]  port_e_pin_i,
	output logic      [3:0]  rdata_o,
	output logic             irq_req_o,
	output logic      [3:0]  port_a_out_o,
	output logic      [3:0]  port_a_oe_n_o,
	output logic      [3:0]  port_b_out_o,
	output logic      [3:0]  port_b_oe_n_o,
	output logic      [3:0]  port_ce_out_o,
	output logic      [3:0]  port_ce_oe_n_o,
	output pnsb_audio_t      audio_o,
	output logic      [1:0]  gain_select_o,
	output logic      [1:0]  frequency_trim_o,
	output logic             record_gain_enable_o,
	output logic             speaker_wake_enable_o
);

	typedef struct packed {
		logic [1:0]  page;
		logic        zero_flag;
		logic        carry_flag;
		logic        pwm_irq_flag;
		logic        pwm_output_enable;
		logic        global_irq_enable;
		logic [3:0]  pce_dir;
		logic [3:0]  pa_dir;
		logic [3:0]  pb_dir;
		logic [3:0]  pa_val;
		logic [3:0]  pb_val;
		logic [3:0]  pc_val;
		logic [3:0]  pe_val;
		logic [3:0]  scr_one;
		logic [3:0]  scr_two;
		logic [3:0]  aud_extra;
		logic [3:0]  aud_low;
		logic [3:0]  aud_high;
		logic [3:0]  gain_trim;
		logic [3:0]  rec_fmt;
		logic [3:0]  spk_wake;
		logic [3:0]  rdata;
	} pnsb_state_t;

	pnsb_state_t st_r;
	pnsb_state_t st_nxt;
	logic [3:0]  ram_mem [RAM_WORDS];

	//////////////////////////////////////////////////////////////////////////
	// Helpers

	// Applies a write or a single-bit operation to a stored nibble
	function automatic logic [3:0] nib_update(input logic [3:0] old,
		input pnsb_req_t r);
		logic [3:0] res;
		res = old;
		if (r.bit_op)
			res[r.bit_sel] = r.bit_set;
		else
			res = r.wdata;
		return res;
	endfunction

	// Output enables are active low: 1 in direction means drive
	function automatic logic [3:0] oe_from_dir(input logic [3:0] dir);
		return ~dir;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Access decode

	logic        is_ram;
	logic        acc_ok;
	logic        do_wr;
	logic [6:0]  ram_idx;
	logic [3:0]  cur_word;
	logic [11:0] sample_w;
	logic [3:0]  status_upd;
	logic [3:0]  pwmc_upd;

	assign is_ram   = req_i.addr[RAM_BASE_BIT];
	assign ram_idx  = {st_r.page, req_i.addr[4:0]};
	// Direct bit operations above 0FH are dropped; indirect ones pass
	assign acc_ok   = !req_i.bit_op || req_i.indirect ||
		(req_i.addr <= ADDR_BITOP_MAX);
	assign do_wr    = req_i.wr && acc_ok;
	// A bit select of a call result is not portable, so the updates get names
	assign status_upd = nib_update({1'b0, st_r.pwm_irq_flag, st_r.carry_flag,
		st_r.zero_flag}, req_i);
	assign pwmc_upd   = nib_update({2'h0, st_r.global_irq_enable,
		st_r.pwm_output_enable}, req_i);

	always_comb
	begin
		unique case (req_i.addr)
			ADDR_PA_VAL:  cur_word = st_r.pa_val;
			ADDR_PB_VAL:  cur_word = st_r.pb_val;
			ADDR_PE_VAL:  cur_word = st_r.pe_val;
			default:      cur_word = ram_mem[ram_idx];
		endcase
	end

	// Sample assembly; twelve-bit option wins over ten-bit
	always_comb
	begin
		if (TWELVE_BIT_OPTION)
			sample_w = {st_r.aud_high, st_r.aud_low, st_r.aud_extra};
		else if (TEN_BIT_OPTION)
			sample_w = {2'h0, st_r.aud_high, st_r.aud_low,
				st_r.aud_extra[3:2]};
		else
			sample_w = {4'h0, st_r.aud_high, st_r.aud_low};
	end

	//////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		st_nxt = st_r;
		if (alu_flags_we_i)
		begin
			st_nxt.carry_flag = carry_in_i;
			st_nxt.zero_flag  = zero_in_i;
		end
		if (page_load_i)
			st_nxt.page = page_data_i;
		if (irq_return_i)
			st_nxt.global_irq_enable = 1'b1;
		if (do_wr && !is_ram)
		begin
			unique case (req_i.addr)
				ADDR_STATUS:
				begin
					st_nxt.zero_flag    = status_upd[ST_ZERO_BIT];
					st_nxt.carry_flag   = status_upd[ST_CARRY_BIT];
					st_nxt.pwm_irq_flag = status_upd[ST_PWMIRQ_BIT];
				end
				ADDR_PCE_DIR:   st_nxt.pce_dir   = nib_update(st_r.pce_dir, req_i);
				ADDR_PA_DIR:    st_nxt.pa_dir    = nib_update(st_r.pa_dir, req_i);
				ADDR_PB_DIR:    st_nxt.pb_dir    = nib_update(st_r.pb_dir, req_i);
				// Bit ops on ports A, B and E modify the pin image, as a read-modify-write would
				ADDR_PA_VAL:    st_nxt.pa_val    = nib_update(port_a_pin_i, req_i);
				ADDR_PB_VAL:    st_nxt.pb_val    = nib_update(port_b_pin_i, req_i);
				ADDR_PC_VAL:    st_nxt.pc_val    = nib_update(st_r.pc_val, req_i);
				ADDR_PE_VAL:    st_nxt.pe_val    = nib_update(port_e_pin_i, req_i);
				ADDR_SCR_ONE:   st_nxt.scr_one   = nib_update(st_r.scr_one, req_i);
				ADDR_SCR_TWO:   st_nxt.scr_two   = nib_update(st_r.scr_two, req_i);
				ADDR_AUD_EXTRA: st_nxt.aud_extra = req_i.wdata;
				ADDR_AUD_LOW:   st_nxt.aud_low   = req_i.wdata;
				ADDR_AUD_HIGH:  st_nxt.aud_high  = req_i.wdata;
				ADDR_PWM_CTRL:
				begin
					st_nxt.pwm_output_enable = pwmc_upd[PC_PWMEN_BIT];
					st_nxt.global_irq_enable = pwmc_upd[PC_GIE_BIT];
				end
				ADDR_GAIN_TRIM: st_nxt.gain_trim = nib_update(st_r.gain_trim, req_i);
				ADDR_REC_FMT:
					st_nxt.rec_fmt = nib_update(st_r.rec_fmt, req_i) & RF_WR_MASK;
				ADDR_SPK_WAKE:
					st_nxt.spk_wake = (nib_update(st_r.spk_wake, req_i) & SW_WR_MASK) |
						(nib_update(st_r.spk_wake, req_i) & st_r.spk_wake &
						~SW_WR_MASK);
				default: ;
			endcase
		end
		// Entry clears only the enable; the flag waits for software
		if (irq_entry_i)
			st_nxt.global_irq_enable = 1'b0;
		// Hardware set wins over a same-cycle software clear
		if (pwm_irq_set_i)
			st_nxt.pwm_irq_flag = 1'b1;
		if (spk_wake_i && st_r.spk_wake[SW_EN_BIT])
			st_nxt.spk_wake[SW_FLAG_BIT] = 1'b1;

		// Read data, registered one cycle after the request
		st_nxt.rdata = UNDEF_READ;
		if (req_i.rd)
		begin
			if (is_ram)
				st_nxt.rdata = ram_mem[ram_idx];
			else
				unique case (req_i.addr)
					ADDR_STATUS:   st_nxt.rdata = {1'b0, st_r.pwm_irq_flag,
						st_r.carry_flag, st_r.zero_flag};
					ADDR_PCE_DIR:  st_nxt.rdata = st_r.pce_dir;
					ADDR_PA_DIR:   st_nxt.rdata = st_r.pa_dir;
					ADDR_PB_DIR:   st_nxt.rdata = st_r.pb_dir;
					ADDR_PA_VAL:   st_nxt.rdata = port_a_pin_i;
					ADDR_PB_VAL:   st_nxt.rdata = port_b_pin_i;
					ADDR_PC_VAL:   st_nxt.rdata = st_r.pc_val;
					ADDR_PE_VAL:   st_nxt.rdata = port_e_pin_i;
					ADDR_SCR_ONE:  st_nxt.rdata = st_r.scr_one;
					ADDR_SCR_TWO:  st_nxt.rdata = st_r.scr_two;
					ADDR_PWM_CTRL: st_nxt.rdata = {2'h0, st_r.global_irq_enable,
						st_r.pwm_output_enable};
					ADDR_GAIN_TRIM: st_nxt.rdata = st_r.gain_trim;
					ADDR_REC_FMT:  st_nxt.rdata = st_r.rec_fmt;
					ADDR_SPK_WAKE: st_nxt.rdata = st_r.spk_wake;
					// Audio nibbles are write-only and read as filler
					default:       st_nxt.rdata = UNDEF_READ;
				endcase
		end

		if (!rstn_i)
		begin
			// Page, port A, B and E values, scratch and audio nibbles keep no reset value
			st_nxt.pwm_irq_flag      = 1'b0;
			st_nxt.pce_dir           = NIB_RESET;
			st_nxt.pa_dir            = NIB_RESET;
			st_nxt.pb_dir            = NIB_RESET;
			st_nxt.pc_val            = NIB_RESET;
			st_nxt.pwm_output_enable = 1'b0;
			st_nxt.global_irq_enable = 1'b0;
			st_nxt.gain_trim         = NIB_RESET;
			st_nxt.rec_fmt           = NIB_RESET;
			st_nxt.spk_wake          = NIB_RESET;
			st_nxt.rdata             = NIB_RESET;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		st_r <= st_nxt;
		if (do_wr && is_ram)
			ram_mem[ram_idx] <= nib_update(cur_word, req_i);
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs, all registered

	logic [3:0] ce_out_nxt;
	logic [3:0] ce_oe_nxt;

	// Combined port: direction register, output-only C, or input-only E
	always_comb
	begin
		if (BIDIR_PORT_OPTION)
		begin
			ce_out_nxt = st_nxt.pe_val;
			ce_oe_nxt  = oe_from_dir(st_nxt.pce_dir);
		end
		else if (PORT_E_MODE_OPTION)
		begin
			ce_out_nxt = st_nxt.pe_val;
			ce_oe_nxt  = 4'hf;
		end
		else
		begin
			ce_out_nxt = st_nxt.pc_val;
			ce_oe_nxt  = 4'h0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		rdata_o               <= st_nxt.rdata;
		irq_req_o             <= st_nxt.pwm_irq_flag && st_nxt.global_irq_enable;
		port_a_out_o          <= st_nxt.pa_val;
		port_a_oe_n_o         <= oe_from_dir(st_nxt.pa_dir);
		port_b_out_o          <= st_nxt.pb_val;
		port_b_oe_n_o         <= oe_from_dir(st_nxt.pb_dir);
		port_ce_out_o         <= ce_out_nxt;
		port_ce_oe_n_o        <= ce_oe_nxt;
		audio_o.sample        <= sample_w;
		audio_o.sign          <= st_r.aud_high[3];
		audio_o.twos_comp     <= st_r.rec_fmt[RF_FMT_BIT];
		audio_o.pwm_en        <= st_r.pwm_output_enable;
		gain_select_o         <= st_r.gain_trim[3:2];
		frequency_trim_o      <= TRIM_OPTION ? st_r.gain_trim[1:0] : 2'h0;
		record_gain_enable_o  <= st_r.rec_fmt[RF_GAIN_BIT];
		speaker_wake_enable_o <= st_r.spk_wake[SW_EN_BIT];
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks

	a_dir_reset_zero: assert property (@(posedge core_clk_i)
		!rstn_i |=> (st_r.pa_dir == 4'h0) && (st_r.pb_dir == 4'h0) ##1
		(port_a_oe_n_o == 4'hf))
		else $error("port direction not cleared by reset");
	a_pb_dir_out: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		##1 port_b_oe_n_o == ~st_r.pb_dir)
		else $error("port b enable does not follow direction");
	a_bitop_blocked: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		req_i.wr && req_i.bit_op && !req_i.indirect && req_i.addr == ADDR_GAIN_TRIM
		&& !irq_entry_i |=> $stable(st_r.gain_trim))
		else $error("direct bit op above 0fh took effect");
	a_irq_entry_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		irq_entry_i && st_r.pwm_irq_flag |=> !st_r.global_irq_enable &&
		st_r.pwm_irq_flag)
		else $error("irq entry handling wrong");
	a_irq_set_wins: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		pwm_irq_set_i |=> st_r.pwm_irq_flag ##1 (rdata_o[2] || !$past(req_i.rd) ||
		$past(req_i.addr) != ADDR_STATUS))
		else $error("irq flag set lost");
	a_status_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		req_i.rd && req_i.addr == ADDR_STATUS |=> rdata_o[3] == 1'b0)
		else $error("status reserved bit not zero");
	a_pin_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		req_i.rd && req_i.addr == ADDR_PA_VAL |=> rdata_o == $past(port_a_pin_i))
		else $error("port a read not pin level");
	a_wake_gated: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!st_r.spk_wake[SW_FLAG_BIT] && !st_r.spk_wake[SW_EN_BIT] && !req_i.wr
		|=> !st_r.spk_wake[SW_FLAG_BIT])
		else $error("wake flag set while disabled");
	a_sample_high: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		req_i.wr && req_i.addr == ADDR_AUD_HIGH |=> ##1
		audio_o.sign == $past(req_i.wdata[3], 2))
		else $error("sample sign not from high nibble");
	// The write-only low audio nibble must survive a stray read
	a_audio_read: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		req_i.rd && !req_i.wr && req_i.addr == ADDR_AUD_LOW |=>
		rdata_o == UNDEF_READ && $stable(st_r.aud_low))
		else $error("audio sample read not harmless");
	a_ce_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		BIDIR_PORT_OPTION && req_i.wr && !req_i.bit_op && req_i.addr == ADDR_PCE_DIR
		|=> port_ce_oe_n_o == ~$past(req_i.wdata))
		else $error("combined port enable does not follow direction");
	// Packing checks for the wider sample options
	a_twelve_pack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		TWELVE_BIT_OPTION && req_i.wr && req_i.addr == ADDR_AUD_EXTRA |=> ##1
		audio_o.sample[3:0] == $past(req_i.wdata, 2))
		else $error("twelve bit sample low bits wrong");
	a_ten_pack: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		TEN_BIT_OPTION && !TWELVE_BIT_OPTION && req_i.wr && req_i.addr == ADDR_AUD_EXTRA
		|=> ##1 audio_o.sample[1:0] == $past(req_i.wdata[3:2], 2))
		else $error("ten bit sample low bits wrong");

endmodule // pnsb_bank
`default_nettype wire

// ==== inc/pnsb_pkg.sv ====
`default_nettype none
package pnsb_pkg;
	localparam logic [5:0] ADDR_STATUS    = 6'h00;
	localparam logic [5:0] ADDR_PCE_DIR   = 6'h01;
	localparam logic [5:0] ADDR_PA_DIR    = 6'h02;
	localparam logic [5:0] ADDR_PA_VAL    = 6'h03;
	localparam logic [5:0] ADDR_PC_VAL    = 6'h04;
	localparam logic [5:0] ADDR_PB_DIR    = 6'h05;
	localparam logic [5:0] ADDR_PB_VAL    = 6'h06;
	localparam logic [5:0] ADDR_SCR_ONE   = 6'h07;
	localparam logic [5:0] ADDR_AUD_EXTRA = 6'h08;
	localparam logic [5:0] ADDR_PWM_CTRL  = 6'h09;
	localparam logic [5:0] ADDR_AUD_LOW   = 6'h0a;
	localparam logic [5:0] ADDR_AUD_HIGH  = 6'h0b;
	localparam logic [5:0] ADDR_PE_VAL    = 6'h0e;
	localparam logic [5:0] ADDR_SCR_TWO   = 6'h0f;
	localparam logic [5:0] ADDR_GAIN_TRIM = 6'h10;
	localparam logic [5:0] ADDR_REC_FMT   = 6'h11;
	localparam logic [5:0] ADDR_SPK_WAKE  = 6'h12;
	localparam logic [5:0] ADDR_BITOP_MAX = 6'h0f;
	localparam int         RAM_BASE_BIT   = 5;
	localparam int         RAM_WORDS      = 128;
	// Field positions
	localparam int ST_ZERO_BIT   = 0;
	localparam int ST_CARRY_BIT  = 1;
	localparam int ST_PWMIRQ_BIT = 2;
	localparam int PC_PWMEN_BIT  = 0;
	localparam int PC_GIE_BIT    = 1;
	localparam int RF_FMT_BIT    = 1;
	localparam int RF_GAIN_BIT   = 3;
	localparam int SW_EN_BIT     = 0;
	localparam int SW_FLAG_BIT   = 3;
	localparam logic [3:0] NIB_RESET   = 4'h0;
	localparam logic [3:0] UNDEF_READ  = 4'h0;
	localparam logic [3:0] SW_WR_MASK  = 4'h7;
	localparam logic [3:0] RF_WR_MASK  = 4'ha;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       bit_op;
		logic       bit_set;
		logic       indirect;
		logic [1:0] bit_sel;
		logic [5:0] addr;
		logic [3:0] wdata;
	} pnsb_req_t;

	typedef struct packed {
		logic [11:0] sample;
		logic        sign;
		logic        twos_comp;
		logic        pwm_en;
	} pnsb_audio_t;
endpackage
`default_nettype wire

// ==== testbench/pnsb_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behavioural core: issues one request at a time on the falling edge
module pnsb_core_model
	import pnsb_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic [3:0] rdata_i,
	output pnsb_req_t       req_o,
	output logic            page_load_o,
	output logic      [1:0] page_data_o
);
	initial
	begin
		req_o       = '0;
		page_load_o = 1'h0;
		page_data_o = 2'h0;
	end
	// Leading wait keeps a clear and the next request out of one time step
	task automatic issue(input pnsb_req_t r);
	begin
		@(negedge core_clk_i);
		req_o = r;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		req_o = '0;
	end
	endtask
	task automatic write_nib(input logic [5:0] a, input logic [3:0] d);
		pnsb_req_t r;
	begin
		r       = '0;
		r.wr    = 1'h1;
		r.addr  = a;
		r.wdata = d;
		issue(r);
	end
	endtask
	task automatic bit_nib(input logic [5:0] a, input logic [1:0] b, input logic s,
			input logic ind);
		pnsb_req_t r;
	begin
		r          = '0;
		r.wr       = 1'h1;
		r.bit_op   = 1'h1;
		r.bit_set  = s;
		r.bit_sel  = b;
		r.indirect = ind;
		r.addr     = a;
		issue(r);
	end
	endtask
	// Answer is launched by the taking edge and stands one cycle
	task automatic read_nib(input logic [5:0] a, output logic [3:0] d);
		pnsb_req_t r;
	begin
		r      = '0;
		r.rd   = 1'h1;
		r.addr = a;
		issue(r);
		d = rdata_i;
	end
	endtask
	// Page select has no reset value, so software loads it before RAM use
	task automatic load_page(input logic [1:0] p);
	begin
		@(negedge core_clk_i);
		page_load_o = 1'h1;
		page_data_o = p;
		@(negedge core_clk_i);
		page_load_o = 1'h0;
	end
	endtask
endmodule // pnsb_core_model
`default_nettype wire

// ==== testbench/tb_pnsb_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_pnsb_bank
	import pnsb_pkg::*;
;
	logic        core_clk = 1'h0;
	logic        rstn;
	logic [4:0]  ev;
	logic [1:0]  cz;
	logic [3:0]  pa_pin, pb_pin, pe_pin, rdata, v;
	logic [3:0]  pa_out, pa_oe_n, pb_out, pb_oe_n, ce_out, ce_oe_n;
	logic [1:0]  gsel, ftrim, pdata;
	logic        irq_req, rge, spk_en, pload;
	pnsb_req_t   req;
	pnsb_audio_t au;
	pnsb_audio_t au12, au10;
	logic [3:0]  ce_out12, ce_oe12, ce_oe10;
	int          n_fail = 0;
	int          tests_run = 0;
	always #2.5 core_clk = ~core_clk;
	pnsb_core_model u_core (.core_clk_i(core_clk), .rdata_i(rdata), .req_o(req),
		.page_load_o(pload), .page_data_o(pdata));
	pnsb_bank #(.BIDIR_PORT_OPTION(1'h1), .TRIM_OPTION(1'h1)) u_dut (
		.core_clk_i(core_clk), .rstn_i(rstn), .req_i(req), .page_load_i(pload),
		.page_data_i(pdata), .alu_flags_we_i(ev[0]), .carry_in_i(cz[1]),
		.zero_in_i(cz[0]), .pwm_irq_set_i(ev[1]), .irq_entry_i(ev[2]),
		.irq_return_i(ev[3]), .spk_wake_i(ev[4]), .port_a_pin_i(pa_pin),
		.port_b_pin_i(pb_pin), .port_e_pin_i(pe_pin), .rdata_o(rdata),
		.irq_req_o(irq_req), .port_a_out_o(pa_out), .port_a_oe_n_o(pa_oe_n),
		.port_b_out_o(pb_out), .port_b_oe_n_o(pb_oe_n), .port_ce_out_o(ce_out),
		.port_ce_oe_n_o(ce_oe_n), .audio_o(au), .gain_select_o(gsel),
		.frequency_trim_o(ftrim), .record_gain_enable_o(rge),
		.speaker_wake_enable_o(spk_en));
	// Wider sample options and the other two combined-port modes
	pnsb_bank #(.TWELVE_BIT_OPTION(1'h1), .PORT_E_MODE_OPTION(1'h0)) u_dut12 (
		.core_clk_i(core_clk), .rstn_i(rstn), .req_i(req), .page_load_i(pload),
		.page_data_i(pdata), .alu_flags_we_i(ev[0]), .carry_in_i(cz[1]),
		.zero_in_i(cz[0]), .pwm_irq_set_i(ev[1]), .irq_entry_i(ev[2]),
		.irq_return_i(ev[3]), .spk_wake_i(ev[4]), .port_a_pin_i(pa_pin),
		.port_b_pin_i(pb_pin), .port_e_pin_i(pe_pin), .rdata_o(),
		.irq_req_o(), .port_a_out_o(), .port_a_oe_n_o(),
		.port_b_out_o(), .port_b_oe_n_o(), .port_ce_out_o(ce_out12),
		.port_ce_oe_n_o(ce_oe12), .audio_o(au12), .gain_select_o(),
		.frequency_trim_o(), .record_gain_enable_o(),
		.speaker_wake_enable_o());
	pnsb_bank #(.TEN_BIT_OPTION(1'h1)) u_dut10 (
		.core_clk_i(core_clk), .rstn_i(rstn), .req_i(req), .page_load_i(pload),
		.page_data_i(pdata), .alu_flags_we_i(ev[0]), .carry_in_i(cz[1]),
		.zero_in_i(cz[0]), .pwm_irq_set_i(ev[1]), .irq_entry_i(ev[2]),
		.irq_return_i(ev[3]), .spk_wake_i(ev[4]), .port_a_pin_i(pa_pin),
		.port_b_pin_i(pb_pin), .port_e_pin_i(pe_pin), .rdata_o(),
		.irq_req_o(), .port_a_out_o(), .port_a_oe_n_o(),
		.port_b_out_o(), .port_b_oe_n_o(), .port_ce_out_o(),
		.port_ce_oe_n_o(ce_oe10), .audio_o(au10), .gain_select_o(),
		.frequency_trim_o(), .record_gain_enable_o(),
		.speaker_wake_enable_o());
	//////////////////////////////////////////////////////////////////////////
	task automatic rchk(input string nm, input logic [5:0] a, input logic [3:0] e);
		logic [3:0] d;
	begin
		u_core.read_nib(a, d);
		`CHK(nm, e, d)
	end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(input int b);
	begin
		@(negedge core_clk);
		ev[b] = 1'h1;
		@(negedge core_clk);
		ev[b] = 1'h0;
	end
	endtask
	task automatic print_verdict();
	begin
		$display("TB counts: tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// Whole sequence takes well under a thousand cycles
	initial
	begin
		#20000;
		n_fail++;
		print_verdict();
	end
	//////////////////////////////////////////////////////////////////////////
	initial
	begin
		rstn = 1'h0;
		ev = 5'h00;
		cz = 2'h0;
		pa_pin = 4'h9;
		pb_pin = 4'h6;
		pe_pin = 4'ha;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'h1;
		rchk("pa_dir_rst", ADDR_PA_DIR, 4'h0);
		rchk("pb_dir_rst", ADDR_PB_DIR, 4'h0);
		rchk("pce_dir_rst", ADDR_PCE_DIR, 4'h0);
		rchk("pc_rst", ADDR_PC_VAL, 4'h0);
		u_core.read_nib(ADDR_STATUS, v);
		`CHK("st_rst", 2'h0, v[3:2])
		`CHK("pa_oe_rst", 4'hf, pa_oe_n)
		`CHK("pb_oe_rst", 4'hf, pb_oe_n)
		// Ports: direction, latch and pin image
		u_core.write_nib(ADDR_PA_DIR, 4'h5);
		u_core.write_nib(ADDR_PA_VAL, 4'h6);
		u_core.write_nib(ADDR_PB_DIR, 4'h3);
		u_core.write_nib(ADDR_PB_VAL, 4'h9);
		u_core.write_nib(ADDR_PCE_DIR, 4'hc);
		u_core.write_nib(ADDR_PE_VAL, 4'h5);
		settle(1);
		`CHK("pa_oe", 4'ha, pa_oe_n)
		`CHK("pb_oe", 4'hc, pb_oe_n)
		`CHK("ce_oe", 4'h3, ce_oe_n)
		`CHK("pa_out", 4'h6, pa_out)
		`CHK("pb_out", 4'h9, pb_out)
		`CHK("ce_out", 4'h5, ce_out)
		rchk("pa_pins", ADDR_PA_VAL, 4'h9);
		rchk("pb_pins", ADDR_PB_VAL, 4'h6);
		rchk("pe_pins", ADDR_PE_VAL, 4'ha);
		pa_pin = 4'h3;
		pb_pin = 4'hc;
		pe_pin = 4'h5;
		rchk("pa_pins2", ADDR_PA_VAL, 4'h3);
		rchk("pb_pins2", ADDR_PB_VAL, 4'hc);
		rchk("pe_pins2", ADDR_PE_VAL, 4'h5);
		u_core.write_nib(ADDR_PC_VAL, 4'hb);
		settle(1);
		`CHK("pc_out", 4'hb, ce_out12)
		`CHK("pc_oe", 4'h0, ce_oe12)
		`CHK("pe_in_oe", 4'hf, ce_oe10)
		rchk("pc_val", ADDR_PC_VAL, 4'hb);
		// Scratch and bit operations at the edge of the direct range
		u_core.write_nib(ADDR_SCR_ONE, 4'h3);
		u_core.write_nib(ADDR_SCR_TWO, 4'hc);
		rchk("scr_one", ADDR_SCR_ONE, 4'h3);
		u_core.bit_nib(ADDR_SCR_TWO, 2'h0, 1'h1, 1'h0);
		rchk("bit_0f", ADDR_SCR_TWO, 4'hd);
		u_core.bit_nib(ADDR_GAIN_TRIM, 2'h3, 1'h1, 1'h0);
		rchk("bit_10_dir", ADDR_GAIN_TRIM, 4'h0);
		u_core.bit_nib(ADDR_GAIN_TRIM, 2'h3, 1'h1, 1'h1);
		rchk("bit_10_ind", ADDR_GAIN_TRIM, 4'h8);
		for (int i = 0; i < 16; i++)
		begin
			u_core.write_nib(ADDR_GAIN_TRIM, 4'(i));
			settle(1);
			`CHK("gain", 2'(i >> 2), gsel)
			`CHK("trim", 2'(i), ftrim)
		end
		// Record gain and sample format; unstored bits read back as zero
		u_core.write_nib(ADDR_REC_FMT, 4'hf);
		rchk("rec_fmt", ADDR_REC_FMT, 4'ha);
		`CHK("rge_on", 1'h1, rge)
		`CHK("twos_on", 1'h1, au.twos_comp)
		u_core.write_nib(ADDR_REC_FMT, 4'h0);
		settle(2);
		`CHK("rge_off", 1'h0, rge)
		`CHK("twos_off", 1'h0, au.twos_comp)
		// Audio sample assembly, sign, and harmless reads
		u_core.write_nib(ADDR_AUD_EXTRA, 4'h5);
		for (int i = 0; i < 2; i++)
		begin
			u_core.write_nib(ADDR_AUD_LOW, i ? 4'h8 : 4'h7);
			u_core.write_nib(ADDR_AUD_HIGH, i ? 4'hc : 4'h3);
			settle(2);
			`CHK("sample", i ? 8'hc8 : 8'h37, au.sample[7:0])
			`CHK("sign", i ? 1'h1 : 1'h0, au.sign)
			`CHK("sample12", i ? 12'hc85 : 12'h375, au12.sample)
			`CHK("sample10", i ? 10'h321 : 10'h0dd, au10.sample[9:0])
		end
		rchk("aud_rd", ADDR_AUD_LOW, UNDEF_READ);
		settle(2);
		`CHK("aud_kept", 8'hc8, au.sample[7:0])
		`CHK("aud_kept12", 12'hc85, au12.sample)
		// PWM enable, interrupt flag, entry and software clear
		u_core.write_nib(ADDR_PWM_CTRL, 4'h3);
		settle(2);
		`CHK("pwm_en", 1'h1, au.pwm_en)
		`CHK("irq_idle", 1'h0, irq_req)
		pulse(1);
		settle(1);
		`CHK("irq_set", 1'h1, irq_req)
		pulse(2);
		settle(1);
		`CHK("irq_entry", 1'h0, irq_req)
		rchk("gie_clr", ADDR_PWM_CTRL, 4'h1);
		u_core.read_nib(ADDR_STATUS, v);
		`CHK("flag_kept", 1'h1, v[2])
		u_core.write_nib(ADDR_STATUS, 4'h0);
		pulse(3);
		u_core.read_nib(ADDR_STATUS, v);
		`CHK("flag_clr", 1'h0, v[2])
		`CHK("irq_ret", 1'h0, irq_req)
		cz = 2'h2;
		pulse(0);
		u_core.read_nib(ADDR_STATUS, v);
		`CHK("cz", 2'h2, v[1:0])
		cz = 2'h1;
		pulse(0);
		u_core.read_nib(ADDR_STATUS, v);
		`CHK("cz_zero", 2'h1, v[1:0])
		// Speaker wake gated by enable, cleared by software
		pulse(4);
		rchk("wk_off", ADDR_SPK_WAKE, 4'h0);
		u_core.write_nib(ADDR_SPK_WAKE, 4'h1);
		settle(1);
		`CHK("wk_en", 1'h1, spk_en)
		pulse(4);
		rchk("wk_set", ADDR_SPK_WAKE, 4'h9);
		u_core.write_nib(ADDR_SPK_WAKE, 4'h1);
		rchk("wk_clr", ADDR_SPK_WAKE, 4'h1);
		// RAM pages keep distinct nibbles; common block ignores the page
		u_core.load_page(2'h0);
		u_core.write_nib(6'h20, 4'h1);
		u_core.load_page(2'h1);
		u_core.write_nib(6'h20, 4'h2);
		u_core.load_page(2'h3);
		u_core.write_nib(6'h3f, 4'he);
		rchk("scr_page3", ADDR_SCR_ONE, 4'h3);
		u_core.load_page(2'h0);
		rchk("ram_p0", 6'h20, 4'h1);
		u_core.load_page(2'h1);
		rchk("ram_p1", 6'h20, 4'h2);
		u_core.load_page(2'h3);
		rchk("ram_p3", 6'h3f, 4'he);
		print_verdict();
	end
endmodule // tb_pnsb_bank
`default_nettype wire
